// [src/mfr_top.sv]
// Purpose: fault stop, relay, indicator and restart manager of a soft
//          start controller
// Assumes: fault conditions come from on-chip detectors on clk_i;
//          rstn_i is the control-power (power-on) reset
// Notes: run command and aux input are pins and are synchronised

`timescale 1ns/1ps

module mfr_top #(
    parameter logic [35:0] RETRY_CYCLES = mfr_pkg::RETRY_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // detector and ramp status
    input wire logic [12:0] fault_cond_i,
    input wire logic selftest_ok_i,
    input wire logic thermal_prealarm_i,
    input wire logic decel_done_i,
    // pins
    input wire logic run_cmd_i,
    input wire logic aux_logic_input_i,
    // outputs
    output logic motor_drive_o,
    output logic freewheel_o,
    output logic fault_relay_o,
    output logic prealarm_output_o,
    output logic fault_lamp_o,
    output logic [3:0] fault_code_o
);

    // ------------------------------------------------------------------
    // pin synchronisation and edges
    // ------------------------------------------------------------------
    logic [1:0] pins_s;
    logic run_lvl;
    logic aux_lvl;
    logic run_prev_q;
    logic aux_prev_q;
    logic run_rise;
    logic run_fall;
    logic aux_rise;

    mfr_sync #(.W(2)) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pin_i({aux_logic_input_i, run_cmd_i}),
        .level_o(pins_s)
    );

    assign run_lvl = pins_s[0];
    assign aux_lvl = pins_s[1];

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            run_prev_q <= 1'b0;
            aux_prev_q <= 1'b0;
        end
        else
        begin
            run_prev_q <= run_lvl;
            aux_prev_q <= aux_lvl;
        end
    end

    assign run_rise = run_lvl & ~run_prev_q;
    assign run_fall = ~run_lvl & run_prev_q;
    assign aux_rise = aux_lvl & ~aux_prev_q;

    // ------------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------------
    logic [5:0] ctrl_q;

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            ctrl_q <= mfr_pkg::CTRL_RST;
        else if (wr_i && addr_i == mfr_pkg::OFS_CTRL)
            ctrl_q <= wdata_i[5:0];
    end

    // ------------------------------------------------------------------
    // fault selection and classification
    // ------------------------------------------------------------------
    logic new_fault;
    logic [3:0] det_code;
    logic [3:0] code_q;
    logic cleared;
    logic ack_ok;
    logic auto_ok;
    mfr_pkg::mfr_class_t cls;

    // lowest index wins when several faults rise together
    always_comb
    begin
        det_code = mfr_pkg::FC_NONE;
        for (int i = mfr_pkg::NUM_FAULTS - 1; i >= 0; i--)
            if (fault_cond_i[i])
                det_code = 4'(i + 1);
    end

    assign new_fault = |fault_cond_i;
    assign cls = mfr_pkg::class_of(code_q);
    assign cleared = (code_q == mfr_pkg::FC_NONE) ||
                     !fault_cond_i[code_q - 4'h1];
    assign auto_ok = ctrl_q[mfr_pkg::CB_AUTO_EN] &
                     ctrl_q[mfr_pkg::CB_TWO_WIRE] & run_lvl;

    // ------------------------------------------------------------------
    // restart state machine
    // ------------------------------------------------------------------
    mfr_pkg::mfr_state_t state_q;
    mfr_pkg::mfr_state_t state_d;
    logic diag_pass_q;
    logic ack_q;
    logic [2:0] attempts_q;
    logic [35:0] timer_q;
    logic retry_fire;
    logic t2_wait;
    logic enter_fault;

    assign t2_wait = (state_q == mfr_pkg::ST_FAULT) &&
                     (cls == mfr_pkg::CL_TYPE2) && auto_ok;
    assign retry_fire = t2_wait && (timer_q == RETRY_CYCLES - 36'h1);
    assign ack_ok = !(ctrl_q[mfr_pkg::CB_AUX_OVL_RESET] &&
                      code_q == mfr_pkg::FC_MOTOR_THERM) || ack_q;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            mfr_pkg::ST_IDLE:
            begin
                if (new_fault)
                    state_d = mfr_pkg::ST_FAULT;
                else if (diag_pass_q && run_lvl)
                    state_d = mfr_pkg::ST_RUN;
            end
            mfr_pkg::ST_RUN:
            begin
                if (new_fault)
                    state_d = mfr_pkg::ST_FAULT;
                else if (!run_lvl && ctrl_q[mfr_pkg::CB_DECEL_EN])
                    state_d = mfr_pkg::ST_DECEL;
                else if (!run_lvl)
                    state_d = mfr_pkg::ST_IDLE;
            end
            mfr_pkg::ST_DECEL:
            begin
                if (new_fault)
                    state_d = mfr_pkg::ST_FAULT;
                else if (decel_done_i)
                    state_d = mfr_pkg::ST_IDLE;
            end
            mfr_pkg::ST_FAULT:
            begin
                if (cls == mfr_pkg::CL_NONRES)
                    state_d = mfr_pkg::ST_LOCKOUT;
                else if (cleared && ack_ok && run_rise)
                    state_d = mfr_pkg::ST_RUN;
                else if (cleared && ack_ok && auto_ok &&
                         cls == mfr_pkg::CL_TYPE1)
                    state_d = mfr_pkg::ST_RUN;
                else if (retry_fire && cleared)
                    state_d = mfr_pkg::ST_RUN;
                else if (retry_fire &&
                         attempts_q == mfr_pkg::MAX_RETRIES - 3'h1)
                    state_d = mfr_pkg::ST_LOCKOUT;
            end
            mfr_pkg::ST_LOCKOUT:
                state_d = mfr_pkg::ST_LOCKOUT;
            default:
                state_d = mfr_pkg::ST_IDLE;
        endcase
    end

    assign enter_fault = (state_d == mfr_pkg::ST_FAULT) &&
                         (state_q != mfr_pkg::ST_FAULT);

    // reset is the control-power cycle; it is the only lockout exit
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            state_q <= mfr_pkg::ST_IDLE;
        else
            state_q <= state_d;
    end

    // self-test pass is sticky until the next power-up
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            diag_pass_q <= 1'b0;
        else if (selftest_ok_i)
            diag_pass_q <= 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            code_q <= mfr_pkg::FC_NONE;
        else if (enter_fault)
            code_q <= det_code;
    end

    // aux pulse only counts once the thermal condition is gone
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            ack_q <= 1'b0;
        else if (enter_fault)
            ack_q <= 1'b0;
        else if (state_q == mfr_pkg::ST_FAULT && cleared && aux_rise)
            ack_q <= 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            timer_q <= '0;
        else if (!t2_wait || retry_fire)
            timer_q <= '0;
        else
            timer_q <= timer_q + 36'h1;
    end

    // failures stay consecutive until an operator stop or manual restart
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            attempts_q <= 3'h0;
        else if (state_q == mfr_pkg::ST_IDLE || run_fall ||
                 (state_q == mfr_pkg::ST_FAULT && run_rise))
            attempts_q <= 3'h0;
        else if (retry_fire && !cleared)
            attempts_q <= attempts_q + 3'h1;
    end

    // ------------------------------------------------------------------
    // fault history
    // ------------------------------------------------------------------
    logic hist_hit;
    logic hist_sel_q;
    logic [3:0] hist_data;
    logic [7:0] hist_ofs;

    assign hist_hit = (addr_i >= mfr_pkg::OFS_HIST0) &&
                      (addr_i <= mfr_pkg::OFS_HIST_LAST) &&
                      (addr_i[1:0] == 2'h0);
    assign hist_ofs = addr_i - mfr_pkg::OFS_HIST0;

    mfr_hist u_hist (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .push_i(enter_fault),
        .code_i(det_code),
        .rd_i(rd_i && hist_hit),
        .idx_i(hist_ofs[4:2]),
        .rdata_o(hist_data)
    );

    // ------------------------------------------------------------------
    // outputs, registered from the next state, the self-test pass or the thermal prealarm input
    // ------------------------------------------------------------------
    logic drive_d;
    logic faulted_d;

    assign drive_d = (state_d == mfr_pkg::ST_RUN) ||
                     (state_d == mfr_pkg::ST_DECEL);
    assign faulted_d = (state_d == mfr_pkg::ST_FAULT) ||
                       (state_d == mfr_pkg::ST_LOCKOUT);

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            motor_drive_o <= 1'b0;
            freewheel_o <= 1'b0;
            fault_lamp_o <= 1'b0;
            fault_code_o <= mfr_pkg::FC_NONE;
        end
        else
        begin
            motor_drive_o <= drive_d;
            freewheel_o <= faulted_d;
            fault_lamp_o <= faulted_d;
            fault_code_o <= enter_fault ? det_code :
                            (faulted_d ? code_q : mfr_pkg::FC_NONE);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            fault_relay_o <= 1'b0;
        else if (ctrl_q[mfr_pkg::CB_RELAY_ISO])
            fault_relay_o <= drive_d;
        else
            fault_relay_o <= (diag_pass_q | selftest_ok_i) &
                             ~faulted_d;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            prealarm_output_o <= 1'b0;
        else if (ctrl_q[mfr_pkg::CB_PREALARM_RUN])
            prealarm_output_o <= drive_d;
        else
            prealarm_output_o <= thermal_prealarm_i;
    end

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    logic [31:0] reg_rdata_q;
    logic [31:0] status;

    always_comb
    begin
        status = 32'h0;
        status[mfr_pkg::SB_CODE +: 4] = code_q;
        status[mfr_pkg::SB_LAMP] = fault_lamp_o;
        status[mfr_pkg::SB_RELAY] = fault_relay_o;
        status[mfr_pkg::SB_STATE +: 3] = state_q;
        status[mfr_pkg::SB_ATTEMPTS +: 3] = attempts_q;
        status[mfr_pkg::SB_DIAG] = diag_pass_q;
        status[mfr_pkg::SB_ACK] = ack_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            reg_rdata_q <= 32'h0;
            hist_sel_q <= 1'b0;
        end
        else
        begin
            hist_sel_q <= rd_i && hist_hit;
            if (!rd_i)
                reg_rdata_q <= 32'h0;
            else if (addr_i == mfr_pkg::OFS_CTRL)
                reg_rdata_q <= {26'h0, ctrl_q};
            else if (addr_i == mfr_pkg::OFS_STATUS)
                reg_rdata_q <= status;
            else
                reg_rdata_q <= 32'h0;
        end
    end

    assign rdata_o = hist_sel_q ? {28'h0, hist_data} : reg_rdata_q;

endmodule

// [src/mfr_pkg.sv]
// Purpose: shared constants and types of the motor fault restart manager
// Assumes: 250 MHz controller clock
// Notes: fault codes double as history entries and display values

package mfr_pkg;

    // ------------------------------------------------------------------
    // fault codes (0 means no fault)
    // ------------------------------------------------------------------
    localparam int NUM_FAULTS = 13;
    localparam int CODE_W = 4;
    localparam logic [3:0] FC_NONE = 4'h0;
    localparam logic [3:0] FC_OVERCURRENT = 4'h1;
    localparam logic [3:0] FC_INTERNAL = 4'h2;
    localparam logic [3:0] FC_PHASE_INV = 4'h3;
    localparam logic [3:0] FC_PHASE_LOSS = 4'h4;
    localparam logic [3:0] FC_LINE_FREQ = 4'h5;
    localparam logic [3:0] FC_SUPPLY_ABSENT = 4'h6;
    localparam logic [3:0] FC_MOTOR_THERM = 4'h7;
    localparam logic [3:0] FC_STARTER_THERM = 4'h8;
    localparam logic [3:0] FC_LOCKED_ROTOR = 4'h9;
    localparam logic [3:0] FC_UNDERLOAD = 4'hA;
    localparam logic [3:0] FC_START_TIME = 4'hB;
    localparam logic [3:0] FC_EXTERNAL = 4'hC;
    localparam logic [3:0] FC_SERIAL_LINK = 4'hD;

    typedef enum logic [1:0]
    {
        CL_NONRES = 2'h0,
        CL_TYPE1 = 2'h1,
        CL_TYPE2 = 2'h2,
        CL_TYPE3 = 2'h3
    } mfr_class_t;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_RUN = 3'h1,
        ST_DECEL = 3'h3,
        ST_FAULT = 3'h2,
        ST_LOCKOUT = 3'h6
    } mfr_state_t;

    // ------------------------------------------------------------------
    // history and retry timing
    // ------------------------------------------------------------------
    localparam int HIST_DEPTH = 5;
    localparam logic [2:0] MAX_RETRIES = 3'h6;
    localparam longint RETRY_TIME_S = 60;
    localparam longint CLK_HZ = 250_000_000;
    localparam logic [35:0] RETRY_CYC = 36'(RETRY_TIME_S * CLK_HZ);

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_HIST0 = 8'h08;
    localparam logic [7:0] OFS_HIST_LAST = 8'h18;

    localparam int CTRL_W = 6;
    localparam int CB_RELAY_ISO = 0;
    localparam int CB_PREALARM_RUN = 1;
    localparam int CB_DECEL_EN = 2;
    localparam int CB_AUTO_EN = 3;
    localparam int CB_TWO_WIRE = 4;
    localparam int CB_AUX_OVL_RESET = 5;
    localparam logic [5:0] CTRL_RST = 6'h10;

    localparam int SB_CODE = 0;
    localparam int SB_LAMP = 4;
    localparam int SB_RELAY = 5;
    localparam int SB_STATE = 6;
    localparam int SB_ATTEMPTS = 9;
    localparam int SB_DIAG = 12;
    localparam int SB_ACK = 13;

    function automatic mfr_class_t class_of(input logic [3:0] code);
        mfr_class_t c;
        c = CL_TYPE3;
        if (code == FC_OVERCURRENT || code == FC_INTERNAL ||
            code == FC_PHASE_INV)
            c = CL_NONRES;
        else if (code == FC_PHASE_LOSS || code == FC_LINE_FREQ)
            c = CL_TYPE1;
        else if (code == FC_SUPPLY_ABSENT)
            c = CL_TYPE2;
        return c;
    endfunction

endpackage

// [src/mfr_sync.sv]
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_i
// Notes: output changes only when stages two and three agree

`timescale 1ns/1ps

module mfr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // pins and filtered levels
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            level_o <= '0;
        else
            for (int i = 0; i < W; i++)
                if (s2_q[i] == s3_q[i])
                    level_o[i] <= s3_q[i];
    end

endmodule

// [src/mfr_hist.sv]
// Purpose: fault history of the most recent codes, newest at entry 0
// Assumes: one push per fault entry
// Notes: read data registered, valid the cycle after rd_i

`timescale 1ns/1ps

module mfr_hist (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // write side
    input wire logic push_i,
    input wire logic [3:0] code_i,
    // read side
    input wire logic rd_i,
    input wire logic [2:0] idx_i,
    output logic [3:0] rdata_o
);

    logic [3:0] mem_q [mfr_pkg::HIST_DEPTH];

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            for (int i = 0; i < mfr_pkg::HIST_DEPTH; i++)
                mem_q[i] <= mfr_pkg::FC_NONE;
        end
        else if (push_i)
        begin
            // oldest falls off the end
            mem_q[0] <= code_i;
            for (int i = 1; i < mfr_pkg::HIST_DEPTH; i++)
                mem_q[i] <= mem_q[i-1];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            rdata_o <= mfr_pkg::FC_NONE;
        else if (rd_i)
        begin
            if (int'(idx_i) < mfr_pkg::HIST_DEPTH)
                rdata_o <= mem_q[idx_i];
            else
                rdata_o <= mfr_pkg::FC_NONE;
        end
    end

endmodule

// [verification/mfr_props.sv]
// Purpose: port-level checks of the fault restart manager
// Assumes: bound to mfr_top, one clock domain
// Notes: a shadow of the control word is kept from bus writes

`timescale 1ns/1ps

module mfr_props (
    // clock, reset and bus
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    // detector inputs
    input wire logic [12:0] fault_cond_i,
    input wire logic thermal_prealarm_i,
    // outputs
    input wire logic motor_drive_o,
    input wire logic freewheel_o,
    input wire logic fault_relay_o,
    input wire logic prealarm_output_o,
    input wire logic fault_lamp_o,
    input wire logic [3:0] fault_code_o
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic [5:0] ctrl_q;

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            ctrl_q <= mfr_pkg::CTRL_RST;
        else if (wr_i && addr_i == mfr_pkg::OFS_CTRL)
            ctrl_q <= wdata_i[5:0];
    end

    // lowest set bit wins
    function automatic logic [3:0] low_code(input logic [12:0] c);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 12; i >= 0; i--)
            if (c[i])
                r = 4'(i + 1);
        return r;
    endfunction

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_hit;
        motor_drive_o && |fault_cond_i;
    endsequence

    sequence s_back;
        freewheel_o ##1 motor_drive_o;
    endsequence

    a_fault_stops_drive: assert property (
        s_hit |=> !motor_drive_o && freewheel_o && fault_lamp_o)
        else $error("drive not stopped on fault");
    a_drive_free_excl: assert property (
        !(motor_drive_o && freewheel_o))
        else $error("drive and freewheel together");
    a_relay_drops: assert property (
        s_hit |=> !fault_relay_o)
        else $error("relay kept on fault");
    a_code_shown: assert property (
        s_hit |=> fault_code_o == low_code($past(fault_cond_i)))
        else $error("wrong fault code");
    a_restart_clean: assert property (
        s_back |-> fault_code_o == 4'h0 && !fault_lamp_o)
        else $error("lamp or code left after restart");
    a_nonres_held: assert property (
        freewheel_o && fault_code_o inside {4'h1, 4'h2, 4'h3}
        |=> freewheel_o && $stable(fault_code_o))
        else $error("non-resettable fault left");
    a_prealarm_follow: assert property (
        !ctrl_q[1] && !$past(ctrl_q[1])
        |-> prealarm_output_o == $past(thermal_prealarm_i))
        else $error("prealarm not following thermal");
    a_relay_contactor: assert property (
        ctrl_q[0] && $past(ctrl_q[0]) |-> fault_relay_o == motor_drive_o)
        else $error("contactor relay off motion");
endmodule

bind mfr_top mfr_props props_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .fault_cond_i(fault_cond_i),
    .thermal_prealarm_i(thermal_prealarm_i),
    .motor_drive_o(motor_drive_o), .freewheel_o(freewheel_o),
    .fault_relay_o(fault_relay_o),
    .prealarm_output_o(prealarm_output_o),
    .fault_lamp_o(fault_lamp_o), .fault_code_o(fault_code_o)
);

// [verification/mfr_far_side.sv]
// Purpose: run switch, aux push-button and isolation contactor
// Assumes: bench requests change on clk_i
// Notes: aux press held six cycles so the pin filter can see it

`timescale 1ns/1ps

module mfr_far_side (
    // clock
    input wire logic clk_i,
    // bench requests
    input wire logic run_req_i,
    input wire logic aux_req_i,
    // device side
    input wire logic fault_relay_i,
    output logic run_cmd_o = 1'b0,
    output logic aux_o,
    output logic contactor_o = 1'b0
);
    logic [2:0] aux_cnt_q = 3'h0;

    always_ff @(posedge clk_i)
    begin
        run_cmd_o <= run_req_i;
        contactor_o <= fault_relay_i;
        if (aux_req_i)
            aux_cnt_q <= 3'h6;
        else if (aux_cnt_q != 3'h0)
            aux_cnt_q <= aux_cnt_q - 3'h1;
    end

    assign aux_o = aux_cnt_q != 3'h0;
endmodule

// [verification/mfr_top_tb.sv]
// Purpose: self-checking bench of the fault restart manager
// Assumes: retry period shortened to 50 cycles
// Notes: pins reach the device through the far side model

`timescale 1ns/1ps

module mfr_top_tb;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [12:0] fault_cond_i = 13'h0;
    logic selftest_ok_i = 1'b0;
    logic thermal_prealarm_i = 1'b0;
    logic decel_done_i = 1'b0;
    logic run_req = 1'b1;
    logic aux_req = 1'b0;
    logic run_cmd, aux_pin, contactor, motor_drive_o, freewheel_o;
    logic fault_relay_o, prealarm_output_o, fault_lamp_o;
    logic [31:0] rdata_o, d;
    logic [3:0] fault_code_o;
    logic [3:0] hist_e [5] = '{default: 4'h0};
    int n_errors = 0;
    int checks_done = 0;

    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    mfr_top #(.RETRY_CYCLES(36'h32)) dut_u (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .fault_cond_i(fault_cond_i), .selftest_ok_i(selftest_ok_i),
        .thermal_prealarm_i(thermal_prealarm_i),
        .decel_done_i(decel_done_i), .run_cmd_i(run_cmd),
        .aux_logic_input_i(aux_pin), .motor_drive_o(motor_drive_o),
        .freewheel_o(freewheel_o), .fault_relay_o(fault_relay_o),
        .prealarm_output_o(prealarm_output_o),
        .fault_lamp_o(fault_lamp_o), .fault_code_o(fault_code_o));

    mfr_far_side far_u (
        .clk_i(clk_i), .run_req_i(run_req), .aux_req_i(aux_req),
        .fault_relay_i(fault_relay_o), .run_cmd_o(run_cmd),
        .aux_o(aux_pin), .contactor_o(contactor));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic rst(input int n);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        cyc(n);
        @(posedge clk_i);
        rstn_i <= 1'b1;
    endtask

    task automatic run_set(input logic v);
        @(posedge clk_i);
        run_req <= v;
    endtask

    // bounded wait, then the drive level is compared
    task automatic wait_drive(input logic exp, input int lim);
        for (int i = 0; i < lim && motor_drive_o !== exp; i++)
            cyc(1);
        chk("drive", motor_drive_o, exp);
    endtask

    task automatic rerun();
        run_set(1'b0);
        cyc(8);
        run_set(1'b1);
        cyc(8);
    endtask

    task automatic inj(input int b);
        @(posedge clk_i);
        fault_cond_i <= 13'h1 << b;
        cyc(2);
        chk("freewheel", freewheel_o, 1'b1);
        chk("lamp", fault_lamp_o, 1'b1);
        chk("code", fault_code_o, 32'(b + 1));
        chk("relay", fault_relay_o, 1'b0);
        for (int i = 4; i > 0; i--)
            hist_e[i] = hist_e[i - 1];
        hist_e[0] = 4'(b + 1);
    endtask

    task automatic clr();
        @(posedge clk_i);
        fault_cond_i <= 13'h0;
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial
    begin
        #100000;
        n_errors++;
        wrap_up();
    end

    initial
    begin
        rst(14);
        rd(mfr_pkg::OFS_CTRL);
        chk("ctrl", d, 32'(mfr_pkg::CTRL_RST));
        wr(mfr_pkg::OFS_STATUS, 32'hFFFF_FFFF);
        rd(mfr_pkg::OFS_STATUS);
        chk("status", d, 32'h0);
        rd(8'h40);
        chk("unmapped", d, 32'h0);
        cyc(10);
        chk("relay", fault_relay_o, 1'b0);
        chk("drive", motor_drive_o, 1'b0);
        @(posedge clk_i);
        selftest_ok_i <= 1'b1;
        wait_drive(1'b1, 10);
        chk("relay", fault_relay_o, 1'b1);
        inj(3);
        clr();
        cyc(20);
        chk("drive", motor_drive_o, 1'b0);
        wr(mfr_pkg::OFS_CTRL, 32'h18);
        for (int b = 3; b < 5; b++)
        begin
            inj(b);
            clr();
            wait_drive(1'b1, 10);
        end
        inj(5);
        clr();
        cyc(30);
        chk("drive", motor_drive_o, 1'b0);
        wait_drive(1'b1, 40);
        for (int b = 6; b < 13; b++)
        begin
            inj(b);
            clr();
            cyc(20);
            chk("drive", motor_drive_o, 1'b0);
            rerun();
            wait_drive(1'b1, 10);
        end
        wr(mfr_pkg::OFS_CTRL, 32'h38);
        inj(6);
        clr();
        rerun();
        chk("drive", motor_drive_o, 1'b0);
        @(posedge clk_i);
        aux_req <= 1'b1;
        @(posedge clk_i);
        aux_req <= 1'b0;
        cyc(12);
        rerun();
        wait_drive(1'b1, 10);
        wr(mfr_pkg::OFS_CTRL, 32'h18);
        @(posedge clk_i);
        thermal_prealarm_i <= 1'b1;
        cyc(2);
        chk("prealarm", prealarm_output_o, 1'b1);
        @(posedge clk_i);
        thermal_prealarm_i <= 1'b0;
        wr(mfr_pkg::OFS_CTRL, 32'h1A);
        cyc(2);
        chk("prealarm", prealarm_output_o, 1'b1);
        for (int i = 0; i < 5; i++)
        begin
            rd(8'(mfr_pkg::OFS_HIST0 + 4 * i));
            chk("hist", d, 32'(hist_e[i]));
        end
        wr(mfr_pkg::OFS_CTRL, 32'h11);
        run_set(1'b0);
        wait_drive(1'b0, 12);
        chk("relay", fault_relay_o, 1'b0);
        cyc(2);
        chk("contactor", contactor, 1'b0);
        run_set(1'b1);
        wait_drive(1'b1, 12);
        chk("relay", fault_relay_o, 1'b1);
        wr(mfr_pkg::OFS_CTRL, 32'h15);
        run_set(1'b0);
        cyc(12);
        chk("relay", fault_relay_o, 1'b1);
        chk("drive", motor_drive_o, 1'b1);
        @(posedge clk_i);
        decel_done_i <= 1'b1;
        @(posedge clk_i);
        decel_done_i <= 1'b0;
        cyc(2);
        chk("relay", fault_relay_o, 1'b0);
        wr(mfr_pkg::OFS_CTRL, 32'h18);
        run_set(1'b1);
        wait_drive(1'b1, 12);
        inj(5);
        cyc(270);
        rd(mfr_pkg::OFS_STATUS);
        chk("state", d[8:6], 32'(mfr_pkg::ST_FAULT));
        chk("retries", d[11:9], 32'h5);
        cyc(50);
        rd(mfr_pkg::OFS_STATUS);
        chk("state", d[8:6], 32'(mfr_pkg::ST_LOCKOUT));
        clr();
        rerun();
        chk("drive", motor_drive_o, 1'b0);
        for (int b = 0; b < 3; b++)
        begin
            rst(4);
            wait_drive(1'b1, 20);
            inj(b);
            rd(mfr_pkg::OFS_STATUS);
            chk("state", d[8:6], 32'(mfr_pkg::ST_LOCKOUT));
            clr();
            rerun();
            chk("drive", motor_drive_o, 1'b0);
        end
        wrap_up();
    end
endmodule
